// [logic/lts_pkg.sv]
package lts_pkg;
    // bus map (byte addresses)
    localparam logic [7:0] LTS_CTRL_OFS = 8'h00;
    localparam logic [7:0] LTS_MCT_OFS = 8'h04;
    localparam logic [7:0] LTS_GCT_OFS = 8'h08;
    localparam logic [7:0] LTS_SFT_OFS = 8'h0C;
    localparam logic [7:0] LTS_SCT_OFS = 8'h10;
    localparam logic [7:0] LTS_STT_OFS = 8'h14;
    localparam logic [7:0] LTS_PCD_OFS = 8'h18;
    localparam logic [7:0] LTS_LIM_OFS = 8'h1C;
    localparam logic [7:0] LTS_PHO_OFS = 8'h20;
    localparam logic [7:0] LTS_RAMP_OFS = 8'h24;
    localparam logic [7:0] LTS_STAT_OFS = 8'h28;
    localparam logic [7:0] LTS_WARN_OFS = 8'h2C;
    localparam logic [7:0] LTS_MEAS_OFS = 8'h30;
    // control bit positions
    localparam int LTS_CTL_REQ_MAINS = 0;
    localparam int LTS_CTL_REQ_GEN = 1;
    localparam int LTS_CTL_NOBRK = 2;
    localparam int LTS_CTL_SOFT = 3;
    localparam int LTS_CTL_AUXFB = 4;
    localparam int LTS_CTL_PHCHK = 5;
    localparam int LTS_CTL_VTUSE = 6;
    // reset values
    localparam logic [31:0] LTS_CTRL_RST = 32'h0000_0020;
    localparam logic [31:0] LTS_TMR_RST = 32'h0000_0100;
    localparam logic [31:0] LTS_LIM_RST = 32'h0001_0A14;
    localparam logic [31:0] LTS_ZERO = 32'h0000_0000;
    // timers count in ticks of this many clocks (1 us at 125 MHz)
    localparam int LTS_CLK_MHZ = 125;
    localparam int LTS_TICK_US = 1;
    localparam int LTS_TICK_CYC = LTS_CLK_MHZ * LTS_TICK_US;
    localparam logic [1:0] LTS_RESP_OK = 2'h0;
    localparam logic [1:0] LTS_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        LTS_IDLE = 4'b0000,
        LTS_OPEN_OUT = 4'b0001,
        LTS_WAIT_IN = 4'b0010,
        LTS_CLOSE_IN = 4'b0011,
        LTS_SYNC = 4'b0100,
        LTS_PARALLEL = 4'b0101,
        LTS_SOFT = 4'b0110,
        LTS_END_PAR = 4'b0111
    } lts_state_t;

    // measured quantities arrive already qualified by the metering front end
    typedef struct packed {
        logic mainsVoltOk;
        logic mainsFreqOk;
        logic genVoltOk;
        logic genFreqOk;
        logic mainsPhaseOrderOk;
        logic genPhaseOrderOk;
        logic [7:0] freqDiff;
        logic [15:0] voltDiff;
        logic [8:0] phaseDiff;
    } lts_meas_t;

    typedef struct packed {
        logic mainsClose;
        logic genClose;
    } lts_coil_t;

    typedef struct packed {
        logic syncFail;
        logic parMainsFail;
        logic rocof;
        logic vectorShift;
        logic underOver;
    } lts_warn_t;
endpackage : lts_pkg

// [logic/lts_load_transfer_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
// Contract
// - to mains: open genset contactor, wait mains delay, close mains contactor
// - to genset: open mains contactor, wait genset delay, close genset contactor
// - make-before-break applies only to genset-to-mains transfers
// - parallel closing needs both voltages and frequencies in limits
// - parallel closing needs correct phase order unless check disabled
// - frequency, L1 voltage and L1 angle differences within maxima
// - keep searching for match until sync failure timer expires
// - match found in time: close both contactors together
// - with feedback: open outgoing once incoming feedback shows closed
// - no feedback: hold both closed for sync contactor timeout, then open
// - no match in time: sync failure warning, finish interrupted
// - no-break enable chooses interrupted-only or make-before-break
// - with VT fitted, scale max voltage difference by VT ratio
// - add phase offset to measured phase difference when matching
// - soft transfer enable; soft starts like make-before-break
// - soft: ramp active and reactive load to mains at set rates
// - soft phase lasts soft timer, then open one contactor
// - any alarm during soft transfer: fall back to interrupted
// - parallel mains protections off until parallel check delay elapses
// - mains fail in parallel: open mains, flag general and specific warning
module lts_load_transfer_sequencer
    import lts_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire lts_meas_t measIn,
    input wire logic mainsFbIn,
    input wire logic genFbIn,
    input wire logic alarmIn,
    input wire logic rocofTripIn,
    input wire logic vectorTripIn,
    input wire logic uoTripIn,
    output lts_coil_t coilOut,
    output logic protEnable,
    output logic rampActive,
    output logic [15:0] kwSetpoint,
    output logic [15:0] kvarSetpoint
);
    logic [31:0] ctrl_q, mct_q, gct_q, sft_q, sct_q, stt_q, pcd_q, lim_q, pho_q, ramp_q;
    lts_warn_t warn_q;
    lts_state_t state_q;
    lts_coil_t coil_q;
    logic toMains_q, mbb_q, soft_q;
    logic [31:0] tmr_q, pcdCnt_q;
    logic [6:0] tick_q;
    logic tick;
    logic [15:0] kw_q, kvar_q;
    // pins are synchronised: two flops, second read only
    lts_meas_t meas1_q, meas_q;
    logic [5:0] pin1_q, pin_q;
    logic mainsFb, genFb, alarm, tripAny;
    logic awHave_q, wHave_q;
    logic [7:0] awa_q;
    logic [31:0] wd_q;
    logic wrFire, wrHit, clrReq;
    logic [31:0] rdMux;
    logic rdHit;
    logic [23:0] voltLimit;
    logic [9:0] phaseAdj;
    logic limitsOk, phaseOrdOk, diffsOk, matchOk;

    always_ff @(posedge clk)
    begin
        meas1_q <= measIn;
        meas_q <= meas1_q;
        pin1_q <= {uoTripIn, vectorTripIn, rocofTripIn, alarmIn, genFbIn, mainsFbIn};
        pin_q <= pin1_q;
    end

    assign genFb = pin_q[1];
    assign mainsFb = pin_q[0];
    assign alarm = pin_q[2];
    assign tripAny = |pin_q[5:3];

    // bus slave: aw and w accepted in either order
    assign s_axi_awready = !awHave_q && !s_axi_bvalid;
    assign s_axi_wready = !wHave_q && !s_axi_bvalid;
    assign wrFire = (awHave_q || s_axi_awvalid) && (wHave_q || s_axi_wvalid) && !s_axi_bvalid;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            awHave_q <= 1'b0;
            wHave_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= LTS_ZERO;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= LTS_RESP_OK;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHave_q <= 1'b1;
                awa_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHave_q <= 1'b1;
                wd_q <= s_axi_wdata;
            end
            if (wrFire)
            begin
                awHave_q <= 1'b0;
                wHave_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrHit ? LTS_RESP_OK : LTS_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic [7:0] wa;
    logic [31:0] wdt;
    assign wa = awHave_q ? awa_q : s_axi_awaddr;
    assign wdt = wHave_q ? wd_q : s_axi_wdata;
    assign wrHit = (wa[7:2] <= LTS_WARN_OFS[7:2]) && (wa[7:2] != LTS_STAT_OFS[7:2]);

    function automatic logic [31:0] lts_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : lts_merge

    logic [3:0] wbe;
    assign wbe = s_axi_wstrb;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_q <= LTS_CTRL_RST;
            mct_q <= LTS_TMR_RST;
            gct_q <= LTS_TMR_RST;
            sft_q <= LTS_TMR_RST;
            sct_q <= LTS_TMR_RST;
            stt_q <= LTS_TMR_RST;
            pcd_q <= LTS_TMR_RST;
            lim_q <= LTS_LIM_RST;
            pho_q <= LTS_ZERO;
            ramp_q <= LTS_ZERO;
        end
        else
        begin
            // request bits are self-clearing pulses
            ctrl_q[1:0] <= 2'b00;
            if (wrFire)
            begin
                case ({wa[7:2], 2'b00})
                    LTS_CTRL_OFS: ctrl_q <= lts_merge(ctrl_q, wdt, wbe);
                    LTS_MCT_OFS: mct_q <= wdt;
                    LTS_GCT_OFS: gct_q <= wdt;
                    LTS_SFT_OFS: sft_q <= wdt;
                    LTS_SCT_OFS: sct_q <= wdt;
                    LTS_STT_OFS: stt_q <= wdt;
                    LTS_PCD_OFS: pcd_q <= wdt;
                    LTS_LIM_OFS: lim_q <= wdt;
                    LTS_PHO_OFS: pho_q <= wdt;
                    LTS_RAMP_OFS: ramp_q <= wdt;
                    default: ctrl_q[1:0] <= 2'b00;
                endcase
            end
        end
    end

    assign clrReq = wrFire && (wa[7:2] == LTS_WARN_OFS[7:2]);

    // read channel
    assign s_axi_arready = !s_axi_rvalid;
    always_comb
    begin
        rdHit = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            LTS_CTRL_OFS: rdMux = ctrl_q;
            LTS_MCT_OFS: rdMux = mct_q;
            LTS_GCT_OFS: rdMux = gct_q;
            LTS_SFT_OFS: rdMux = sft_q;
            LTS_SCT_OFS: rdMux = sct_q;
            LTS_STT_OFS: rdMux = stt_q;
            LTS_PCD_OFS: rdMux = pcd_q;
            LTS_LIM_OFS: rdMux = lim_q;
            LTS_PHO_OFS: rdMux = pho_q;
            LTS_RAMP_OFS: rdMux = ramp_q;
            LTS_STAT_OFS:
                rdMux = {20'h0, genFb, mainsFb, protEnable, rampActive, coil_q, state_q, mbb_q,
                         soft_q};
            LTS_WARN_OFS: rdMux = {27'h0, warn_q};
            LTS_MEAS_OFS: rdMux = {kvar_q, kw_q};
            default:
            begin
                rdMux = LTS_ZERO;
                rdHit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= LTS_ZERO;
            s_axi_rresp <= LTS_RESP_OK;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdHit ? LTS_RESP_OK : LTS_RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // match check: lim = {volt max[15:0], phase max[7:0]... } packed as
    // [7:0] freq max, [15:8] phase max, [31:16] volt max; vt/ramp in pho/ramp words
    // VT ratio scales voltage limit
    assign voltLimit = ctrl_q[LTS_CTL_VTUSE] ? 24'(lim_q[31:16]) * 24'(pho_q[31:24])
                                            : {8'h00, lim_q[31:16]};
    assign phaseAdj = 10'({1'b0, meas_q.phaseDiff} + {1'b0, pho_q[8:0]});
    assign limitsOk = meas_q.mainsVoltOk && meas_q.mainsFreqOk && meas_q.genVoltOk && meas_q.genFreqOk;
    assign phaseOrdOk = !ctrl_q[LTS_CTL_PHCHK] || (meas_q.mainsPhaseOrderOk && meas_q.genPhaseOrderOk);
    assign diffsOk = (meas_q.freqDiff <= lim_q[7:0]) && ({8'h00, meas_q.voltDiff} <= voltLimit)
                     && (phaseAdj <= {2'b00, lim_q[15:8]});
    assign matchOk = limitsOk && phaseOrdOk && diffsOk;

    // tick prescaler for all timers
    always_ff @(posedge clk)
    begin
        if (srst || tick)
            tick_q <= 7'h00;
        else
            tick_q <= tick_q + 7'h01;
    end
    assign tick = (tick_q == 7'(LTS_TICK_CYC - 1));

    logic reqMains, reqGen;
    assign reqMains = ctrl_q[LTS_CTL_REQ_MAINS];
    assign reqGen = ctrl_q[LTS_CTL_REQ_GEN];

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state_q <= LTS_IDLE;
            coil_q <= '0;
            toMains_q <= 1'b0;
            mbb_q <= 1'b0;
            soft_q <= 1'b0;
            tmr_q <= LTS_ZERO;
        end
        else
        begin
            if (tick && tmr_q != LTS_ZERO)
                tmr_q <= tmr_q - 32'h1;
            case (state_q)
                LTS_IDLE:
                begin
                    if (reqMains)
                    begin
                        toMains_q <= 1'b1;
                        if (ctrl_q[LTS_CTL_NOBRK] && coil_q.genClose)
                        begin
                            mbb_q <= 1'b1;
                            soft_q <= ctrl_q[LTS_CTL_SOFT];
                            tmr_q <= sft_q;
                            state_q <= LTS_SYNC;
                        end
                        else
                        begin
                            state_q <= LTS_OPEN_OUT;
                        end
                    end
                    else if (reqGen)
                    begin
                        toMains_q <= 1'b0;
                        state_q <= LTS_OPEN_OUT;
                    end
                end
                LTS_SYNC:
                begin
                    if (matchOk)
                    begin
                        coil_q <= '{mainsClose: 1'b1, genClose: 1'b1};
                        tmr_q <= soft_q ? stt_q : sct_q;
                        state_q <= soft_q ? LTS_SOFT : LTS_PARALLEL;
                    end
                    // search until timer expiry, then interrupted
                    else if (tmr_q == LTS_ZERO)
                    begin
                        mbb_q <= 1'b0;
                        soft_q <= 1'b0;
                        state_q <= LTS_OPEN_OUT;
                    end
                end
                LTS_PARALLEL:
                begin
                    if ((ctrl_q[LTS_CTL_AUXFB] && mainsFb) || (!ctrl_q[LTS_CTL_AUXFB] && tmr_q == LTS_ZERO))
                        state_q <= LTS_END_PAR;
                end
                LTS_SOFT:
                begin
                    if (alarm)
                    begin
                        coil_q.mainsClose <= 1'b0;
                        tmr_q <= LTS_ZERO;
                        mbb_q <= 1'b0;
                        soft_q <= 1'b0;
                        state_q <= LTS_OPEN_OUT;
                    end
                    else if (tmr_q == LTS_ZERO)
                        state_q <= LTS_END_PAR;
                end
                LTS_END_PAR:
                begin
                    coil_q.genClose <= 1'b0;
                    mbb_q <= 1'b0;
                    soft_q <= 1'b0;
                    state_q <= LTS_IDLE;
                end
                LTS_OPEN_OUT:
                begin
                    coil_q <= '0;
                    tmr_q <= toMains_q ? mct_q : gct_q;
                    state_q <= LTS_WAIT_IN;
                end
                LTS_WAIT_IN:
                begin
                    if (tmr_q == LTS_ZERO)
                        state_q <= LTS_CLOSE_IN;
                end
                LTS_CLOSE_IN:
                begin
                    coil_q.mainsClose <= toMains_q;
                    coil_q.genClose <= !toMains_q;
                    state_q <= LTS_IDLE;
                end
                default: state_q <= LTS_IDLE;
            endcase
            // mains fail in parallel: open mains at once
            if (protEnable && tripAny)
            begin
                coil_q.mainsClose <= 1'b0;
                state_q <= LTS_IDLE;
                mbb_q <= 1'b0;
                soft_q <= 1'b0;
            end
        end
    end

    // protections armed after parallel check delay
    always_ff @(posedge clk)
    begin
        if (srst || !(coil_q.mainsClose && coil_q.genClose))
            pcdCnt_q <= LTS_ZERO;
        else if (tick && pcdCnt_q != pcd_q)
            pcdCnt_q <= pcdCnt_q + 32'h1;
    end
    assign protEnable = coil_q.mainsClose && coil_q.genClose && (pcdCnt_q == pcd_q);

    // warnings: hardware set wins over software clear
    always_ff @(posedge clk)
    begin
        if (srst)
            warn_q <= '0;
        else
        begin
            if (clrReq)
                warn_q <= warn_q & ~lts_warn_t'(wdt[4:0]);
            if (state_q == LTS_SYNC && !matchOk && tmr_q == LTS_ZERO)
                warn_q.syncFail <= 1'b1;
            if (protEnable && tripAny)
            begin
                warn_q.parMainsFail <= 1'b1;
                if (pin_q[3])
                    warn_q.rocof <= 1'b1;
                if (pin_q[4])
                    warn_q.vectorShift <= 1'b1;
                if (pin_q[5])
                    warn_q.underOver <= 1'b1;
            end
        end
    end

    assign rampActive = (state_q == LTS_SOFT);
    always_ff @(posedge clk)
    begin
        if (srst || !rampActive)
        begin
            kw_q <= 16'h0000;
            kvar_q <= 16'h0000;
        end
        else if (tick)
        begin
            kw_q <= (kw_q > 16'hFFFF - ramp_q[15:0]) ? 16'hFFFF : 16'(kw_q + ramp_q[15:0]);
            kvar_q <= (kvar_q > 16'hFFFF - ramp_q[31:16]) ? 16'hFFFF : 16'(kvar_q + ramp_q[31:16]);
        end
    end

    assign coilOut = coil_q;
    assign kwSetpoint = kw_q;
    assign kvarSetpoint = kvar_q;
endmodule : lts_load_transfer_sequencer
`default_nettype wire

// [tb/lts_contactor_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lts_contactor_model
    import lts_pkg::*;
#(
    parameter int FB_DLY = 4
)
(
    input wire logic clk,
    input wire logic srst,
    input wire lts_coil_t coil,
    output logic mainsFb,
    output logic genFb
);
    // armature travel: auxiliary contacts trail the coil, never lead it
    logic [FB_DLY-1:0] mainsSh_q;
    logic [FB_DLY-1:0] genSh_q;
    always_ff @(posedge clk)
    begin
        mainsSh_q <= {mainsSh_q[FB_DLY-2:0], coil.mainsClose & ~srst};
        genSh_q <= {genSh_q[FB_DLY-2:0], coil.genClose & ~srst};
    end
    assign mainsFb = mainsSh_q[FB_DLY-1];
    assign genFb = genSh_q[FB_DLY-1];
endmodule : lts_contactor_model
`default_nettype wire

// [tb/lts_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module lts_monitor
    import lts_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire lts_meas_t measIn,
    input wire logic alarmIn,
    input wire logic rocofTripIn,
    input wire logic vectorTripIn,
    input wire logic uoTripIn,
    input wire lts_coil_t coilOut,
    input wire logic protEnable,
    input wire logic rampActive,
    input wire logic [15:0] kwSetpoint
);
    // holds only while every contactor timer is at least two ticks
    localparam int GAP_MIN = 120;
    logic both;
    logic tripAny;
    logic measOk;
    logic [15:0] openCnt_q;
    assign both = coilOut.mainsClose && coilOut.genClose;
    assign tripAny = rocofTripIn || vectorTripIn || uoTripIn;
    assign measOk = measIn.mainsVoltOk && measIn.mainsFreqOk && measIn.genVoltOk && measIn.genFreqOk;
    always_ff @(posedge clk)
    begin
        if (srst || coilOut.mainsClose || coilOut.genClose)
            openCnt_q <= 16'h0000;
        else if (openCnt_q != 16'hFFFF)
            openCnt_q <= openCnt_q + 16'h0001;
    end
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (srst);
    a_mains_after_gap:
        assert property ($rose(coilOut.mainsClose) && !coilOut.genClose |-> openCnt_q >= GAP_MIN)
        else $error("mains closed without dead time");
    a_gen_after_gap:
        assert property ($rose(coilOut.genClose) && !coilOut.mainsClose |-> openCnt_q >= GAP_MIN)
        else $error("genset closed without dead time");
    a_mbb_from_gen:
        assert property ($rose(both) |-> $past(coilOut.genClose) && !$past(coilOut.mainsClose))
        else $error("overlap not from genset side");
    a_par_meas_ok:
        assert property ($rose(both) |-> $past(measOk, 3))
        else $error("overlap with measurements out of limits");
    a_overlap_bound:
        assert property (both && !rampActive |-> ##[1:400] (!both || rampActive))
        else $error("overlap not ended in time");
    a_ramp_in_par:
        assert property (rampActive |-> both)
        else $error("ramp outside parallel");
    a_ramp_moves:
        assert property ($rose(rampActive) |-> ##[1:300] kwSetpoint != $past(kwSetpoint))
        else $error("active setpoint not ramping");
    a_soft_ends:
        assert property ($fell(rampActive) |-> ##[0:3] !both)
        else $error("parallel kept after soft phase");
    a_prot_late:
        assert property ($rose(protEnable) |-> $past(coilOut.mainsClose, 100))
        else $error("protections armed too early");
    a_fail_trip:
        assert property (protEnable && tripAny |-> ##[1:6] !coilOut.mainsClose)
        else $error("mains kept after trip");
    a_soft_alarm:
        assert property (rampActive && alarmIn |-> ##[1:6] !coilOut.mainsClose)
        else $error("soft transfer not abandoned");
    c_parallel: cover property ($rose(both));
    c_soft_done: cover property ($fell(rampActive) && coilOut.mainsClose);
    c_trip: cover property (protEnable && tripAny);
endmodule : lts_monitor
bind lts_load_transfer_sequencer lts_monitor i_lts_monitor (
    .clk(clk),
    .srst(srst),
    .measIn(measIn),
    .alarmIn(alarmIn),
    .rocofTripIn(rocofTripIn),
    .vectorTripIn(vectorTripIn),
    .uoTripIn(uoTripIn),
    .coilOut(coilOut),
    .protEnable(protEnable),
    .rampActive(rampActive),
    .kwSetpoint(kwSetpoint)
);
`default_nettype wire

// [tb/lts_load_transfer_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module lts_load_transfer_sequencer_tb;
    import lts_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    lts_meas_t measIn = {6'h3F, 8'h14, 16'h0000, 9'h002};
    logic mainsFbIn, genFbIn, protEnable, rampActive;
    logic alarmIn = 1'b0;
    logic rocofTripIn = 1'b0;
    logic vectorTripIn = 1'b0;
    logic uoTripIn = 1'b0;
    lts_coil_t coilOut;
    int fails = 0;
    int checksDone = 0;

    lts_load_transfer_sequencer i_lts_load_transfer_sequencer (
        .clk(clk), .srst(srst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .measIn(measIn),
        .mainsFbIn(mainsFbIn), .genFbIn(genFbIn), .alarmIn(alarmIn), .rocofTripIn(rocofTripIn),
        .vectorTripIn(vectorTripIn), .uoTripIn(uoTripIn), .coilOut(coilOut),
        .protEnable(protEnable), .rampActive(rampActive), .kwSetpoint(), .kvarSetpoint()
    );
    lts_contactor_model i_lts_contactor_model (
        .clk(clk), .srst(srst), .coil(coilOut), .mainsFb(mainsFbIn), .genFb(genFbIn)
    );

    initial
    begin
        forever #4 clk = ~clk;
    end

    task automatic wrap_up();
        if (fails == 0 && checksDone > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        checksDone++;
        if (s !== e)
        begin
            fails++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask : check

    task automatic guard(input logic ok, input string nm);
        if (ok !== 1'b1)
        begin
            check(nm, 32'h0, 32'h1);
            wrap_up();
        end
    endtask : guard

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aTk, wTk, got;
        got = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50 && !got; n++)
        begin
            @(negedge clk);
            aTk = s_axi_awvalid && s_axi_awready;
            wTk = s_axi_wvalid && s_axi_wready;
            got = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (aTk)
                s_axi_awvalid <= 1'b0;
            if (wTk)
                s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        guard(got, "write timeout");
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic aTk, got;
        got = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50 && !got; n++)
        begin
            @(negedge clk);
            aTk = s_axi_arvalid && s_axi_arready;
            got = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (aTk)
                s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        guard(got, "read timeout");
    endtask : axr

    task automatic wait_coil(input logic [1:0] e, input int lim, input logic noBoth);
        @(negedge clk);
        for (int n = 0; n < lim && coilOut !== e; n++)
        begin
            @(negedge clk);
            if (noBoth && coilOut === 2'b11)
                check("both coils", 32'h3, 32'h0);
        end
        check("coil state", {30'h0, coilOut}, {30'h0, e});
        guard(coilOut === e, "coil timeout");
        @(posedge clk);
    endtask : wait_coil

    task automatic go(input logic [7:0] m, input logic [1:0] e, input logic noBoth);
        axw(LTS_CTRL_OFS, 32'h20 | {24'h0, m}, rsp);
        wait_coil(e, 3000, noBoth);
    endtask : go

    task automatic soft_up();
        go(8'h0D, 2'b11, 1'b0);
        repeat (500) @(negedge clk);
        check("protections armed", {31'h0, protEnable}, 32'h1);
        check("ramp running", {31'h0, rampActive}, 32'h1);
        axr(LTS_MEAS_OFS, rd, rsp);
        check("ramp ratio", {16'h0, rd[15:0]}, {15'h0, rd[31:16], 1'b0});
    endtask : soft_up

    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        axr(LTS_CTRL_OFS, rd, rsp);
        check("ctrl reset", rd, LTS_CTRL_RST);
        axr(8'h3C, rd, rsp);
        check("unmapped resp", {30'h0, rsp}, {30'h0, LTS_RESP_SLVERR});
        axw(LTS_STAT_OFS, 32'h0000_0001, rsp);
        check("read-only resp", {30'h0, rsp}, {30'h0, LTS_RESP_SLVERR});
        for (int i = 1; i < 7; i++)
            axw(8'(4 * i), 32'h0000_0002, rsp);
        axw(LTS_STT_OFS, 32'h0000_0008, rsp);
        axw(LTS_RAMP_OFS, 32'h0001_0002, rsp);
        go(8'h02, 2'b01, 1'b1);
        go(8'h01, 2'b10, 1'b1);
        go(8'h02, 2'b01, 1'b1);
        go(8'h05, 2'b11, 1'b0);
        repeat (60) @(negedge clk);
        check("overlap held", {30'h0, coilOut}, 32'h3);
        wait_coil(2'b10, 3000, 1'b0);
        go(8'h06, 2'b01, 1'b1);
        go(8'h15, 2'b11, 1'b0);
        wait_coil(2'b10, 60, 1'b0);
        go(8'h16, 2'b01, 1'b1);
        measIn.freqDiff <= 8'h15;
        go(8'h05, 2'b10, 1'b1);
        axr(LTS_WARN_OFS, rd, rsp);
        check("sync warning", rd, 32'h0000_0010);
        measIn <= {6'h37, 8'h14, 16'h0000, 9'h002};
        go(8'h02, 2'b01, 1'b1);
        go(8'h05, 2'b10, 1'b1);
        axw(LTS_WARN_OFS, 32'h0000_001F, rsp);
        measIn.genVoltOk <= 1'b1;
        go(8'h02, 2'b01, 1'b1);
        soft_up();
        wait_coil(2'b10, 3000, 1'b0);
        go(8'h02, 2'b01, 1'b1);
        soft_up();
        @(posedge clk);
        rocofTripIn <= 1'b1;
        wait_coil(2'b01, 20, 1'b0);
        axr(LTS_WARN_OFS, rd, rsp);
        check("mains fail warnings", rd, 32'h0000_000C);
        rocofTripIn <= 1'b0;
        soft_up();
        @(posedge clk);
        alarmIn <= 1'b1;
        wait_coil(2'b01, 20, 1'b0);
        wait_coil(2'b10, 3000, 1'b1);
        wrap_up();
    end
endmodule : lts_load_transfer_sequencer_tb
`default_nettype wire
